// ### shared/csr_map.svh
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// i/o offsets of the special register group
`define CSR_OFF_GUARD 6'h04
`define CSR_OFF_ZPAGE 6'h0b
`define CSR_OFF_JPAGE 6'h0c
`define CSR_OFF_SPLO 6'h0d
`define CSR_OFF_SPHI 6'h0e
`define CSR_OFF_FLAGS 6'h0f

// flag bit positions
`define CSR_BIT_IE 3'd7
`define CSR_BIT_T 3'd6
`define CSR_BIT_H 3'd5
`define CSR_BIT_S 3'd4
`define CSR_BIT_V 3'd3
`define CSR_BIT_N 3'd2
`define CSR_BIT_Z 3'd1
`define CSR_BIT_C 3'd0

// guard signatures and reset values
`define CSR_SIG_IOREG 8'hd8
`define CSR_SIG_SPM 8'h9d
`define CSR_FLAGS_RST 8'h00
`define CSR_SP_RST 16'hffff

// protection windows, in instruction cycles
`define CSR_GUARD_CYCLES 3'd4
`define CSR_SPLOCK_INSNS 3'd4

`endif

// ### shared/csr_pkg.sv
package csr_pkg;

    // i/o register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csr_io_req_t;

    // flag update from the alu
    typedef struct packed {
        logic valid;
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } csr_alu_flags_t;

    // guard window states
    typedef enum logic [2:0] {
        CSR_G_IDLE = 3'b001,
        CSR_G_IO = 3'b010,
        CSR_G_SPM = 3'b100
    } csr_guard_state_t;

endpackage

// ### rtl/csr_window_cnt.sv
`timescale 1ns/10ps
`include "csr_map.svh"

// counts down a window of instruction cycles; start reloads, stop ends it
module csr_window_cnt #(
    parameter logic [2:0] LEN = 3'd4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic stop,
    input wire logic step,
    // state
    output logic active
);
    logic [2:0] cnt;
    logic [2:0] next_cnt;

    // start wins over stop so a fresh window is never lost
    always_comb begin
        next_cnt = cnt;
        if (start) begin
            next_cnt = LEN;
        end else if (stop) begin
            next_cnt = 3'h0;
        end else if (step && cnt != 3'h0) begin
            next_cnt = cnt - 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 3'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign active = (cnt != 3'h0);
endmodule

// ### rtl/csr_wait_gen.sv
`timescale 1ns/10ps
`include "csr_map.svh"

// one-cycle wait state when a flags write flips the global enable
module csr_wait_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request
    input wire logic flags_wr,
    input wire logic ie_now,
    input wire logic ie_new,
    // result
    output logic wait_req,
    output logic commit
);
    logic held;
    logic next_held;

    // first cycle stalls the access, second cycle commits it
    always_comb begin
        next_held = 1'b0;
        if (flags_wr && (ie_now != ie_new) && !held) begin
            next_held = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            held <= 1'b0;
        end else begin
            held <= next_held;
        end
    end

    assign wait_req = flags_wr && (ie_now != ie_new) && !held;
    assign commit = flags_wr && !wait_req;
endmodule

// ### rtl/csr_special_regs.sv
`timescale 1ns/10ps
`include "csr_map.svh"

module csr_special_regs
    import csr_pkg::*;
#(
    parameter logic [15:0] SP_RESET = `CSR_SP_RST
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // i/o register port
    input csr_pkg::csr_io_req_t io_req,
    output logic [7:0] io_rdata,
    output logic io_wait,
    // core instruction controls
    input wire logic insn_step,
    input csr_pkg::csr_alu_flags_t alu_flags,
    input wire logic int_on_op,
    input wire logic int_off_op,
    input wire logic reg_bit_to_flag_op,
    input wire logic reg_bit_in,
    input wire logic mem_wr,
    input wire logic spm_lpm_op,
    input wire logic sleep_op,
    input wire logic sp_load,
    input wire logic [15:0] sp_new,
    // interrupt gating
    input wire logic int_pending,
    input wire logic int_taken,
    output logic int_grant,
    // register values to the core
    output logic [7:0] cpu_flags,
    output logic flag_to_reg_bit,
    output logic [15:0] stack_ptr,
    output logic [7:0] ext_z_page,
    output logic [7:0] ext_jump_page,
    output logic io_unlock,
    output logic spm_unlock
);
    import csr_pkg::*;

    logic [7:0] next_flags;
    logic [15:0] next_sp;
    logic [7:0] next_zpage;
    logic [7:0] next_jpage;
    logic wr_splo, wr_sphi, wr_flags, wr_z, wr_j, wr_guard;
    logic flags_commit;
    logic sig_io, sig_spm;
    logic other_wr;
    logic splock;
    logic [7:0] wflags;
    logic s_bit;

    // address decode of i/o writes
    assign wr_guard = io_req.wr && io_req.addr == `CSR_OFF_GUARD;
    assign wr_z = io_req.wr && io_req.addr == `CSR_OFF_ZPAGE;
    assign wr_j = io_req.wr && io_req.addr == `CSR_OFF_JPAGE;
    assign wr_splo = io_req.wr && io_req.addr == `CSR_OFF_SPLO;
    assign wr_sphi = io_req.wr && io_req.addr == `CSR_OFF_SPHI;
    assign wr_flags = io_req.wr && io_req.addr == `CSR_OFF_FLAGS;

    // global enable change through i/o stalls the access once
    csr_wait_gen u_wait (
        .core_clk(core_clk),
        .rst(rst),
        .flags_wr(wr_flags),
        .ie_now(cpu_flags[`CSR_BIT_IE]),
        .ie_new(io_req.wdata[`CSR_BIT_IE]),
        .wait_req(io_wait),
        .commit(flags_commit)
    );

    // guard signatures; any write to another offset or to memory closes the i/o window
    assign sig_io = wr_guard && io_req.wdata == `CSR_SIG_IOREG;
    assign sig_spm = wr_guard && io_req.wdata == `CSR_SIG_SPM;
    assign other_wr = (io_req.wr && !wr_guard) || mem_wr;

    csr_window_cnt #(.LEN(`CSR_GUARD_CYCLES)) u_guard_io (
        .core_clk(core_clk),
        .rst(rst),
        .start(sig_io),
        .stop(other_wr || spm_lpm_op || sleep_op),
        .step(insn_step),
        .active(io_unlock)
    );

    csr_window_cnt #(.LEN(`CSR_GUARD_CYCLES)) u_guard_spm (
        .core_clk(core_clk),
        .rst(rst),
        .start(sig_spm),
        .stop(mem_wr || sleep_op),
        .step(insn_step),
        .active(spm_unlock)
    );

    // stack low byte write blocks interrupts, a later i/o write ends it
    csr_window_cnt #(.LEN(`CSR_SPLOCK_INSNS)) u_splock (
        .core_clk(core_clk),
        .rst(rst),
        .start(wr_splo),
        .stop(io_req.wr || mem_wr),
        .step(insn_step),
        .active(splock)
    );

    // interrupts pass only with global enable and no protection window
    assign int_grant = int_pending && cpu_flags[`CSR_BIT_IE]
        && !splock && !io_unlock && !spm_unlock;

    // flags next value; alu update first, then dedicated ops, then i/o
    always_comb begin
        wflags = cpu_flags;
        if (alu_flags.valid) begin
            wflags[`CSR_BIT_H] = alu_flags.h;
            wflags[`CSR_BIT_V] = alu_flags.v;
            wflags[`CSR_BIT_N] = alu_flags.n;
            wflags[`CSR_BIT_Z] = alu_flags.z;
            wflags[`CSR_BIT_C] = alu_flags.c;
        end
        if (reg_bit_to_flag_op) begin
            wflags[`CSR_BIT_T] = reg_bit_in;
        end
        if (int_on_op) begin
            wflags[`CSR_BIT_IE] = 1'b1;
        end else if (int_off_op) begin
            wflags[`CSR_BIT_IE] = 1'b0;
        end
        // int_taken is deliberately ignored here
        if (wr_flags && flags_commit) begin
            wflags = io_req.wdata;
        end
        // sign is derived, never stored on its own
        s_bit = wflags[`CSR_BIT_N] ^ wflags[`CSR_BIT_V];
        wflags[`CSR_BIT_S] = s_bit;
        next_flags = wflags;
    end

    // stack pointer and extended pages
    always_comb begin
        next_sp = stack_ptr;
        next_zpage = ext_z_page;
        next_jpage = ext_jump_page;
        if (sp_load) begin
            next_sp = sp_new;
        end
        if (wr_splo) begin
            next_sp[7:0] = io_req.wdata;
        end
        if (wr_sphi) begin
            next_sp[15:8] = io_req.wdata;
        end
        if (wr_z) begin
            next_zpage = io_req.wdata;
        end
        if (wr_j) begin
            next_jpage = io_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_flags <= `CSR_FLAGS_RST;
            stack_ptr <= SP_RESET; // top of stack after reset
            ext_z_page <= 8'h00;
            ext_jump_page <= 8'h00;
        end else begin
            cpu_flags <= next_flags;
            stack_ptr <= next_sp;
            ext_z_page <= next_zpage;
            ext_jump_page <= next_jpage;
        end
    end

    assign flag_to_reg_bit = cpu_flags[`CSR_BIT_T];

    // read mux; unmapped offsets read zero
    always_comb begin
        io_rdata = 8'h00;
        case (io_req.addr)
            `CSR_OFF_GUARD: io_rdata = {6'h00, spm_unlock, io_unlock};
            `CSR_OFF_ZPAGE: io_rdata = ext_z_page;
            `CSR_OFF_JPAGE: io_rdata = ext_jump_page;
            `CSR_OFF_SPLO: io_rdata = stack_ptr[7:0];
            `CSR_OFF_SPHI: io_rdata = stack_ptr[15:8];
            `CSR_OFF_FLAGS: io_rdata = cpu_flags;
            default: io_rdata = 8'h00;
        endcase
    end
endmodule

// ### test/csr_chk.sv
`timescale 1ns/10ps
// watches the special register group from its ports only
module csr_chk
    import csr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // i/o side
    input csr_pkg::csr_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic io_wait,
    // core side
    input csr_pkg::csr_alu_flags_t alu_flags,
    input wire logic int_on_op,
    input wire logic int_off_op,
    input wire logic reg_bit_to_flag_op,
    input wire logic reg_bit_in,
    input wire logic int_pending,
    input wire logic int_taken,
    input wire logic int_grant,
    input wire logic [7:0] cpu_flags,
    input wire logic flag_to_reg_bit,
    input wire logic io_unlock
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // flag relations
    a_sign_xor: assert property (cpu_flags[4] == ^cpu_flags[3:2])
        else $error("sign bit wrong");
    a_alu_load: assert property (alu_flags.valid |=>
        cpu_flags[5] == $past(alu_flags.h)
        && cpu_flags[3:0] == $past(alu_flags[3:0])) else $error("alu flags");
    a_tbit_copy: assert property (reg_bit_to_flag_op |=>
        flag_to_reg_bit == $past(reg_bit_in)) else $error("bit copy");
    // global enable
    a_ie_mask: assert property (int_grant |-> cpu_flags[7])
        else $error("grant while disabled");
    a_int_on: assert property (int_on_op |=> cpu_flags[7])
        else $error("enable not set");
    a_ie_kept: assert property (int_taken && cpu_flags[7]
        && !int_off_op && !io_req.wr |=> cpu_flags[7]) else $error("ie lost");
    a_wait_flip: assert property (io_req.wr && io_req.addr == 6'h0f
        && io_req.wdata[7] != cpu_flags[7] && !$past(io_wait) |-> io_wait
        ##1 !io_wait) else $error("wait state");
    // locks and guard
    a_splo_lock: assert property (io_req.wr && io_req.addr == 6'h0d
        |=> !int_grant) else $error("grant after low sp write");
    a_guard_open: assert property (io_req.wr && io_req.addr == 6'h04
        && io_req.wdata == 8'hd8 |=> io_unlock) else $error("guard closed");
    a_guard_hi: assert property (io_req.addr == 6'h04
        |-> io_rdata[7:2] == 6'h00) else $error("guard high bits");
    c_wait: cover property (io_wait);
    c_unlock: cover property (io_unlock);
    c_grant: cover property (int_grant);
endmodule

bind csr_special_regs csr_chk i_csr_chk (.core_clk(core_clk), .rst(rst),
    .io_req(io_req), .io_rdata(io_rdata), .io_wait(io_wait),
    .alu_flags(alu_flags), .int_on_op(int_on_op), .int_off_op(int_off_op),
    .reg_bit_to_flag_op(reg_bit_to_flag_op), .reg_bit_in(reg_bit_in),
    .int_pending(int_pending), .int_taken(int_taken),
    .int_grant(int_grant), .cpu_flags(cpu_flags),
    .flag_to_reg_bit(flag_to_reg_bit), .io_unlock(io_unlock));

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import csr_pkg::*;
    logic core_clk = 0;
    logic rst = 1;
    csr_io_req_t io_req = '0;
    csr_alu_flags_t alu = '0;
    logic [9:0] ctl = '0;
    logic pend = 1;
    logic [7:0] rd, fl, zp, jp, lf = 8'h4e;
    logic [15:0] spn = '0;
    logic [7:0] mr [16];
    logic iow, gr, t2r, iou, spu, sw;
    logic [15:0] sp;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int m_fl = 0;
    int i;
    // ctl bits: step, on, off, bit store, mem wr, spm, sleep, sp load,
    // taken, bit in
    csr_special_regs #(.SP_RESET(16'hffff)) i_csr_special_regs (
        .core_clk(core_clk), .rst(rst), .io_req(io_req), .io_rdata(rd),
        .io_wait(iow), .insn_step(ctl[0]), .alu_flags(alu),
        .int_on_op(ctl[1]), .int_off_op(ctl[2]),
        .reg_bit_to_flag_op(ctl[3]), .reg_bit_in(ctl[9]),
        .mem_wr(ctl[4]), .spm_lpm_op(ctl[5]), .sleep_op(ctl[6]),
        .sp_load(ctl[7]), .sp_new(spn), .int_pending(pend),
        .int_taken(ctl[8]), .int_grant(gr), .cpu_flags(fl),
        .flag_to_reg_bit(t2r), .stack_ptr(sp), .ext_z_page(zp),
        .ext_jump_page(jp), .io_unlock(iou), .spm_unlock(spu));
    initial forever #20 core_clk = ~core_clk;
    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish;
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task tally_and_finish;
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // write held through one wait cycle if the design asks for it
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_req <= '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        sw = iow;
        if (iow === 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        io_req <= '0;
        // settle before any check reads what this write launched
        @(negedge core_clk);
    endtask
    task rdc(input logic [5:0] a, input logic [7:0] e);
        @(posedge core_clk);
        io_req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        chk("io_rdata", e, rd);
    endtask
    task pulse(input logic [9:0] v);
        @(posedge core_clk);
        ctl <= v;
        @(posedge core_clk);
        ctl <= '0;
        @(negedge core_clk);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("cpu_flags", 0, fl);
        rdc(6'h04, 8'h00);
        rdc(6'h05, 8'h00);
        for (i = 11; i < 15; i++) begin
            lf = lfsr(lf);
            mr[i] = lf;
            wr(i[5:0], lf);
            rdc(i[5:0], lf);
        end
        chk("stack_ptr", {mr[14], mr[13]}, sp);
        chk("pages", {mr[12], mr[11]}, {jp, zp});
        @(posedge core_clk);
        spn <= {lf, ~lf};
        pulse(10'h080);
        chk("stack_ptr", {lf, ~lf}, sp);
        for (i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            @(posedge core_clk);
            alu <= {1'b1, lf[4:0]};
            @(posedge core_clk);
            alu <= '0;
            @(negedge core_clk);
            m_fl = {2'b00, lf[4], lf[2] ^ lf[3], lf[3:0]};
            chk("cpu_flags", m_fl, fl);
        end
        pulse(10'h208);
        chk("flag_to_reg_bit", 1, t2r);
        pulse(10'h008);
        chk("flag_to_reg_bit", 0, t2r);
        chk("int_grant", 0, gr);
        pulse(10'h002);
        chk("cpu_flags", m_fl | 8'h80, fl);
        chk("int_grant", 1, gr);
        @(posedge core_clk);
        pend <= 1'b0;
        @(negedge core_clk);
        chk("int_grant", 0, gr);
        @(posedge core_clk);
        pend <= 1'b1;
        pulse(10'h100);
        chk("cpu_flags", m_fl | 8'h80, fl);
        // low sp write masks for four steps
        wr(6'h0d, 8'h55);
        chk("int_grant", 0, gr);
        repeat (3) pulse(10'h001);
        chk("int_grant", 0, gr);
        pulse(10'h001);
        chk("int_grant", 1, gr);
        // a later i/o write ends the low sp lock early
        wr(6'h0d, 8'h55);
        wr(6'h0b, 8'h00);
        chk("int_grant", 1, gr);
        wr(6'h04, 8'hd8);
        rdc(6'h04, 8'h01);
        chk("io_unlock", 1, iou);
        chk("int_grant", 0, gr);
        repeat (3) pulse(10'h001);
        rdc(6'h04, 8'h01);
        pulse(10'h001);
        rdc(6'h04, 8'h00);
        wr(6'h04, 8'h9d);
        rdc(6'h04, 8'h02);
        pulse(10'h010);
        chk("spm_unlock", 0, spu);
        wr(6'h0f, 8'h00);
        chk("io_wait", 1, sw);
        rdc(6'h0f, 8'h00);
        wr(6'h0f, 8'h08);
        chk("io_wait", 0, sw);
        rdc(6'h0f, 8'h18);
        pulse(10'h002);
        pulse(10'h004);
        chk("cpu_flags", 8'h18, fl);
        tally_and_finish;
    end
endmodule
